// ### wcr_pkg.sv
// Package with constants and types of the waveform capture recorder
package wcr_pkg;
  // ****************************************
  // APB register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMES = 8'h04;
  localparam logic [7:0] ADDR_STAGE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_RD_INDEX = 8'h18;
  localparam logic [7:0] ADDR_RD_DATA = 8'h1c;
  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SRC_LSB = 4;
  localparam logic [3:0] PRE_RESET = 4'h3;
  localparam logic [3:0] POST_RESET = 4'h3;
  localparam logic [1:0] SRC_RESET = 2'h2;
  localparam logic [5:0] STAGE_RESET = 6'h3f;
  localparam int NUM_STAGES = 6;
  localparam int NUM_CH = 4;
  localparam int MAX_RECORDS = 10;
  localparam int TOTAL_TENTHS = 30;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVERWRITE = 1;
  // ****************************************
  // Trigger source and recorder states
  // ****************************************
  typedef enum logic [1:0] {
    SRC_DISABLED = 2'b00,
    SRC_START = 2'b01,
    SRC_TRIP = 2'b10,
    SRC_EXTERNAL = 2'b11
  } wcr_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POST = 2'b01,
    ST_COPY = 2'b10
  } wcr_state_t;
endpackage

// ### wcr_trigger.sv
// Trigger selection of the waveform capture recorder
`timescale 1ns/1ps
`default_nettype none
module wcr_trigger (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings
  input wire logic enable,
  input wire logic [1:0] source,
  input wire logic [5:0] stage_part,
  // Events
  input wire logic [5:0] stage_start,
  input wire logic [5:0] stage_trip,
  input wire logic breaker_position_input,
  // Result
  output logic trigger
);
  logic [5:0] start_q;
  logic [5:0] trip_q;
  logic brk_q;
  logic start_ev;
  logic trip_ev;
  logic ext_ev;

  // Previous levels for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= 6'h00;
      trip_q <= 6'h00;
      brk_q <= 1'b0;
    end else begin
      start_q <= stage_start;
      trip_q <= stage_trip;
      brk_q <= breaker_position_input;
    end
  end

  // Rising edges of participating stages only, falling edge of the breaker input
  assign start_ev = |(stage_start & ~start_q & stage_part);
  assign trip_ev = |(stage_trip & ~trip_q & stage_part);
  assign ext_ev = brk_q & ~breaker_position_input;

  // Source selection gated by enable
  always_comb begin
    trigger = 1'b0;
    case (wcr_pkg::wcr_src_t'(source))
      wcr_pkg::SRC_START: trigger = start_ev;
      wcr_pkg::SRC_TRIP: trigger = trip_ev;
      wcr_pkg::SRC_EXTERNAL: trigger = ext_ev;
      default: trigger = 1'b0;
    endcase
    if (!enable) begin
      trigger = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### wcr_recorder.sv
// Top of the waveform capture recorder with APB registers and record memory
`timescale 1ns/1ps
`default_nettype none
module wcr_recorder #(
  parameter int SAMPLES_PER_TENTH = 4,
  parameter int SW = 16
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sample stream
  input wire logic SAMPLE_VALID,
  input wire logic [SW-1:0] PHASE_A_CURRENT,
  input wire logic [SW-1:0] PHASE_B_CURRENT,
  input wire logic [SW-1:0] PHASE_C_CURRENT,
  input wire logic [SW-1:0] EARTH_CURRENT,
  // Protection stage and breaker events
  input wire logic [5:0] STAGE_START,
  input wire logic [5:0] STAGE_TRIP,
  input wire logic BREAKER_POSITION_INPUT,
  // Interrupt
  output logic IRQ
);
  // ****************************************
  // Sizes
  // ****************************************
  localparam int MEM_DEPTH = wcr_pkg::TOTAL_TENTHS * SAMPLES_PER_TENTH;
  localparam int AW = $clog2(MEM_DEPTH + 1);
  localparam int DW = SW * wcr_pkg::NUM_CH;
  localparam int PRE_DEPTH = 15 * SAMPLES_PER_TENTH;
  localparam int PW = $clog2(PRE_DEPTH + 1);
  localparam logic [AW-1:0] MEM_LAST = AW'(MEM_DEPTH - 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(PRE_DEPTH - 1);
  localparam logic [AW-1:0] SPT = AW'(SAMPLES_PER_TENTH);

  // ****************************************
  // Registers
  // ****************************************
  logic function_enable_setting;
  logic [1:0] trig_source;
  logic [3:0] pre_trigger_time;
  logic [3:0] post_trigger_time;
  logic [5:0] stage_part;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [AW-1:0] rd_index;
  logic [DW-1:0] rd_word;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic done_ev;
  logic over_ev;
  logic trigger;

  // ****************************************
  // Storage and state
  // ****************************************
  logic [DW-1:0] pre_buf [PRE_DEPTH];
  logic [DW-1:0] mem [MEM_DEPTH];
  logic [PW-1:0] pre_wr;
  logic [PW-1:0] pre_fill;
  logic [PW-1:0] pre_rd;
  logic [PW-1:0] copy_left;
  logic [AW-1:0] mem_wr;
  logic [AW-1:0] post_left;
  logic [AW-1:0] rec_len;
  logic [AW-1:0] pre_len;
  logic [3:0] rec_count;
  logic [3:0] max_records;
  wcr_pkg::wcr_state_t state;
  logic [DW-1:0] sample;
  logic [4:0] time_sum;
  logic [PW-1:0] pre_take;

  assign sample = {EARTH_CURRENT, PHASE_C_CURRENT, PHASE_B_CURRENT, PHASE_A_CURRENT};
  assign pre_len = AW'(pre_trigger_time) * SPT;
  // Pre plus post in five bits, so that long windows cannot wrap to zero
  assign time_sum = {1'b0, pre_trigger_time} + {1'b0, post_trigger_time};
  assign rec_len = AW'(time_sum) * SPT;
  // Pre-trigger samples really held, short after reset
  assign pre_take = (pre_fill < PW'(pre_len)) ? pre_fill : PW'(pre_len);

  // Record count limit from memory size, capped at ten
  always_comb begin
    max_records = 4'h0;
    if (time_sum != 5'h00) begin
      max_records = 4'(wcr_pkg::TOTAL_TENTHS / int'(time_sum));
      if (wcr_pkg::TOTAL_TENTHS / int'(time_sum) > wcr_pkg::MAX_RECORDS) begin
        max_records = 4'(wcr_pkg::MAX_RECORDS);
      end
    end
  end

  // ****************************************
  // Trigger selection
  // ****************************************
  wcr_trigger u_trig (
    .clk(MCLK),
    .rst(RST),
    .enable(function_enable_setting),
    .source(trig_source),
    .stage_part(stage_part),
    .stage_start(STAGE_START),
    .stage_trip(STAGE_TRIP),
    .breaker_position_input(BREAKER_POSITION_INPUT),
    .trigger(trigger)
  );

  // ****************************************
  // APB slave
  // ****************************************
  assign PREADY = 1'b1;
  assign addr_ok = (PADDR[7:5] == 3'h0) && (PADDR[1:0] == 2'h0);
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  // Settings written by software
  always_ff @(posedge MCLK) begin
    if (RST) begin
      function_enable_setting <= 1'b1;
      trig_source <= wcr_pkg::SRC_RESET;
      pre_trigger_time <= wcr_pkg::PRE_RESET;
      post_trigger_time <= wcr_pkg::POST_RESET;
      stage_part <= wcr_pkg::STAGE_RESET;
      irq_mask <= 2'h0;
      rd_index <= '0;
    end else if (wr_en) begin
      case (PADDR)
        wcr_pkg::ADDR_CTRL: begin
          function_enable_setting <= PWDATA[wcr_pkg::CTRL_EN_BIT];
          trig_source <= PWDATA[wcr_pkg::CTRL_SRC_LSB +: 2];
        end
        wcr_pkg::ADDR_TIMES: begin
          if (PWDATA[3:0] != 4'h0 && PWDATA[3:0] <= 4'hf) begin
            pre_trigger_time <= PWDATA[3:0];
          end
          if (PWDATA[11:8] != 4'h0 && PWDATA[11:8] <= 4'hf) begin
            post_trigger_time <= PWDATA[11:8];
          end
        end
        wcr_pkg::ADDR_STAGE: stage_part <= PWDATA[5:0];
        wcr_pkg::ADDR_IRQ_MASK: irq_mask <= PWDATA[1:0];
        wcr_pkg::ADDR_RD_INDEX: rd_index <= PWDATA[AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PRDATA <= 32'h0;
    end else if (rd_en) begin
      case (PADDR)
        wcr_pkg::ADDR_CTRL: PRDATA <= {26'h0, trig_source, 3'h0, function_enable_setting};
        wcr_pkg::ADDR_TIMES: PRDATA <= {20'h0, post_trigger_time, 4'h0, pre_trigger_time};
        wcr_pkg::ADDR_STAGE: PRDATA <= {26'h0, stage_part};
        wcr_pkg::ADDR_STATUS: PRDATA <= {16'h0, 4'h0, max_records, rec_count, 2'h0, state};
        wcr_pkg::ADDR_IRQ_STAT: PRDATA <= {30'h0, irq_stat};
        wcr_pkg::ADDR_IRQ_MASK: PRDATA <= {30'h0, irq_mask};
        wcr_pkg::ADDR_RD_INDEX: PRDATA <= 32'(rd_index);
        wcr_pkg::ADDR_RD_DATA: PRDATA <= rd_word[31:0];
        default: PRDATA <= 32'h0;
      endcase
    end
  end

  assign rd_word = (rd_index < AW'(MEM_DEPTH)) ? mem[rd_index] : '0;

  // Sticky interrupt status, set wins over clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_en && PADDR == wcr_pkg::ADDR_IRQ_STAT) ? PWDATA[1:0] : 2'h0))
                  | {over_ev, done_ev};
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  // ****************************************
  // Continuous pre-trigger buffer
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pre_wr <= '0;
      pre_fill <= '0;
    end else if (SAMPLE_VALID) begin
      pre_buf[pre_wr] <= sample;
      pre_wr <= (pre_wr == PRE_LAST) ? '0 : pre_wr + 1'b1;
      if (pre_fill != PW'(PRE_DEPTH)) begin
        pre_fill <= pre_fill + 1'b1;
      end
    end
  end

  // ****************************************
  // Recording sequence
  // ****************************************
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state <= wcr_pkg::ST_IDLE;
      mem_wr <= '0;
      post_left <= '0;
      pre_rd <= '0;
      copy_left <= '0;
      rec_count <= 4'h0;
      done_ev <= 1'b0;
      over_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      over_ev <= 1'b0;
      case (state)
        wcr_pkg::ST_IDLE: begin
          if (trigger) begin
            // Snapshot pre-trigger start; wrap write pointer to keep records contiguous
            copy_left <= pre_take;
            pre_rd <= (pre_wr >= pre_take) ? pre_wr - pre_take : pre_wr + PW'(PRE_DEPTH) - pre_take;
            post_left <= AW'(post_trigger_time) * SPT;
            if ({1'b0, mem_wr} + {1'b0, rec_len} > (AW + 1)'(MEM_DEPTH)) begin
              mem_wr <= '0;
            end
            if (rec_count >= max_records) begin
              over_ev <= 1'b1;
            end
            state <= wcr_pkg::ST_COPY;
          end
        end
        wcr_pkg::ST_COPY: begin
          // Copy the ring oldest first; samples arriving meanwhile queue behind and count as post
          if (SAMPLE_VALID && post_left != '0) begin
            post_left <= post_left - 1'b1;
          end
          if (copy_left != '0) begin
            mem[mem_wr] <= pre_buf[pre_rd];
            mem_wr <= (mem_wr == MEM_LAST) ? '0 : mem_wr + 1'b1;
            pre_rd <= (pre_rd == PRE_LAST) ? '0 : pre_rd + 1'b1;
            if (!(SAMPLE_VALID && post_left != '0)) begin
              copy_left <= copy_left - 1'b1;
            end
          end else if (SAMPLE_VALID && post_left != '0) begin
            copy_left <= PW'(1);
          end else begin
            state <= wcr_pkg::ST_POST;
          end
        end
        wcr_pkg::ST_POST: begin
          // Triggers are not looked at here
          if (SAMPLE_VALID && post_left != '0) begin
            mem[mem_wr] <= sample;
            mem_wr <= (mem_wr == MEM_LAST) ? '0 : mem_wr + 1'b1;
            post_left <= post_left - 1'b1;
          end else if (post_left == '0) begin
            if (rec_count < max_records) begin
              rec_count <= rec_count + 1'b1;
            end
            done_ev <= 1'b1;
            state <= wcr_pkg::ST_IDLE;
          end
        end
        default: state <= wcr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_busy;
    state != wcr_pkg::ST_IDLE;
  endsequence

  a_no_trig_off: assert property (@(posedge MCLK) disable iff (RST)
    !function_enable_setting |-> !trigger) else $error("trigger while disabled");
  a_disabled_src: assert property (@(posedge MCLK) disable iff (RST)
    trig_source == wcr_pkg::SRC_DISABLED |-> !trigger) else $error("trigger with source disabled");
  a_trig_starts: assert property (@(posedge MCLK) disable iff (RST)
    state == wcr_pkg::ST_IDLE && trigger |=> state == wcr_pkg::ST_COPY) else $error("trigger not taken");
  a_busy_ignore: assert property (@(posedge MCLK) disable iff (RST)
    s_busy and (state == wcr_pkg::ST_POST && post_left != '0) |=> state != wcr_pkg::ST_COPY) else $error("retrigger");
  a_count_cap: assert property (@(posedge MCLK) disable iff (RST)
    rec_count <= 4'(wcr_pkg::MAX_RECORDS)) else $error("too many records");
  a_mem_bound: assert property (@(posedge MCLK) disable iff (RST)
    mem_wr < AW'(MEM_DEPTH)) else $error("memory pointer out of range");
  a_done_idle: assert property (@(posedge MCLK) disable iff (RST)
    done_ev |-> state == wcr_pkg::ST_IDLE && $past(post_left) == '0) else $error("done early");
  a_ext_edge: assert property (@(posedge MCLK) disable iff (RST)
    function_enable_setting && trig_source == wcr_pkg::SRC_EXTERNAL && $fell(BREAKER_POSITION_INPUT)
    |-> trigger) else $error("breaker opening missed");
endmodule
`default_nettype wire

// ### wcr_stage_model.sv
// Behavioural model of the protection stages, breaker input and sample source
`timescale 1ns/1ps
`default_nettype none
module wcr_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic fire,
  input wire logic [1:0] kind,
  input wire logic [2:0] idx,
  // Stage and breaker levels
  output logic [5:0] stage_start,
  output logic [5:0] stage_trip,
  output logic breaker,
  // Sample stream
  output logic sample_valid,
  output logic [15:0] cur_a,
  output logic [15:0] cur_b,
  output logic [15:0] cur_c,
  output logic [15:0] cur_e
);
  logic [3:0] age;
  logic [15:0] cnt;
  // Stage starts timing, trips five cycles later, drops after ten
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_start <= 6'h00;
      stage_trip <= 6'h00;
      age <= 4'h0;
    end else if (fire && kind == 2'h0) begin
      stage_start <= 6'h01 << idx;
      age <= 4'h1;
    end else if (age != 4'h0) begin
      age <= age + 4'h1;
      if (age == 4'h5) stage_trip <= stage_start;
      if (age == 4'ha) begin
        stage_start <= 6'h00;
        stage_trip <= 6'h00;
        age <= 4'h0;
      end
    end
  end
  // Breaker opens on kind 1 and closes on kind 2, closed after reset
  always_ff @(posedge clk) begin
    if (rst) breaker <= 1'b1;
    else if (fire && kind == 2'h1) breaker <= 1'b0;
    else if (fire && kind == 2'h2) breaker <= 1'b1;
  end
  // One sample every other cycle, channels tied by known relations
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_valid <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      sample_valid <= ~sample_valid;
      if (sample_valid) cnt <= cnt + 16'h0001;
    end
  end
  assign cur_a = cnt;
  assign cur_b = cnt + 16'h0001;
  assign cur_c = ~cnt;
  assign cur_e = cnt ^ 16'h5555;
endmodule
`default_nettype wire

// ### wcr_recorder_test.sv
// Self-checking testbench of the waveform capture recorder
`timescale 1ns/1ps
`default_nettype none
module wcr_recorder_test;
  logic MCLK, RST, psel, penable, pwrite, fire, pready, pslverr, irq, sv, brk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0] kind;
  logic [2:0] idx;
  logic [5:0] st_s, st_t;
  logic [15:0] ca, cb, cc, ce;
  logic e;
  int n_fail, num_checks, ncnt, k;
  // ****************************************
  // Clock, design and partner
  // ****************************************
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  wcr_recorder #(.SAMPLES_PER_TENTH(4), .SW(16)) i_dut (.MCLK(MCLK), .RST(RST), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAMPLE_VALID(sv), .PHASE_A_CURRENT(ca),
    .PHASE_B_CURRENT(cb), .PHASE_C_CURRENT(cc), .EARTH_CURRENT(ce), .STAGE_START(st_s),
    .STAGE_TRIP(st_t), .BREAKER_POSITION_INPUT(brk), .IRQ(irq));
  wcr_stage_model i_model (.clk(MCLK), .rst(RST), .fire(fire), .kind(kind), .idx(idx),
    .stage_start(st_s), .stage_trip(st_t), .breaker(brk), .sample_valid(sv),
    .cur_a(ca), .cur_b(cb), .cur_c(cc), .cur_e(ce));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge MCLK);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge MCLK);
    penable <= 1'b1;
    @(posedge MCLK);
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge MCLK);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk(n, r & m, x);
  endtask
  // Event on the far side, then a settle time
  task automatic ev(input logic [1:0] kd, input logic [2:0] ix, input int w);
    @(posedge MCLK);
    fire <= 1'b1;
    kind <= kd;
    idx <= ix;
    @(posedge MCLK);
    fire <= 1'b0;
    repeat (w) @(posedge MCLK);
  endtask
  // Wait for the done interrupt, then clear it
  task automatic rec_done();
    int i;
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge MCLK);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(wcr_pkg::ADDR_IRQ_STAT, 32'h1);
    @(posedge MCLK);
    #1 chk("irq clear", {31'h0, irq}, 32'h0);
  endtask
  task automatic cnt_chk();
    rd_chk("count", wcr_pkg::ADDR_STATUS, 32'hf0, 32'(ncnt << 4));
  endtask
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    {RST, psel, penable, pwrite, fire, paddr, pwdata, kind, idx} = '0;
    RST = 1'b1;
    n_fail = 0;
    num_checks = 0;
    ncnt = 0;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    rd_chk("ctrl", wcr_pkg::ADDR_CTRL, 32'hffffffff, 32'h21);
    rd_chk("times", wcr_pkg::ADDR_TIMES, 32'hffffffff, 32'h303);
    rd_chk("stage", wcr_pkg::ADDR_STAGE, 32'hffffffff, 32'h3f);
    rd_chk("max", wcr_pkg::ADDR_STATUS, 32'hf00, 32'h500);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("bad read", r, 32'h0);
    wr(wcr_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(wcr_pkg::ADDR_CTRL, 32'h20);
    ev(2'h0, 3'h0, 60);
    cnt_chk();
    wr(wcr_pkg::ADDR_CTRL, 32'h01);
    ev(2'h0, 3'h0, 60);
    cnt_chk();
    wr(wcr_pkg::ADDR_STAGE, 32'h3e);
    wr(wcr_pkg::ADDR_CTRL, 32'h11);
    ev(2'h0, 3'h0, 60);
    cnt_chk();
    ev(2'h0, 3'h3, 60);
    rec_done();
    ncnt = 1;
    cnt_chk();
    wr(wcr_pkg::ADDR_CTRL, 32'h21);
    ev(2'h0, 3'h5, 60);
    rec_done();
    ncnt = 2;
    cnt_chk();
    // Second opening arrives while the first record still runs
    wr(wcr_pkg::ADDR_CTRL, 32'h31);
    ev(2'h1, 3'h0, 4);
    ev(2'h2, 3'h0, 4);
    ev(2'h1, 3'h0, 60);
    rec_done();
    ncnt = 3;
    cnt_chk();
    ev(2'h2, 3'h0, 60);
    cnt_chk();
    wr(wcr_pkg::ADDR_RD_INDEX, 32'h0);
    apb(1'b0, wcr_pkg::ADDR_RD_DATA, 32'h0, r, e);
    chk("pair", {16'h0, r[31:16]}, {16'h0, r[15:0] + 16'h0001});
    wr(wcr_pkg::ADDR_TIMES, 32'h505);
    rd_chk("max", wcr_pkg::ADDR_STATUS, 32'hf00, 32'h300);
    wr(wcr_pkg::ADDR_TIMES, 32'h101);
    rd_chk("max", wcr_pkg::ADDR_STATUS, 32'hf00, 32'ha00);
    for (k = 0; k < 11; k++) begin
      ev(2'h1, 3'h0, 40);
      rec_done();
      ev(2'h2, 3'h0, 4);
    end
    ncnt = 10;
    cnt_chk();
    rd_chk("overwrite", wcr_pkg::ADDR_IRQ_STAT, 32'h3, 32'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(wcr_pkg::ADDR_IRQ_MASK, 32'h3);
    @(posedge MCLK);
    #1 chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(wcr_pkg::ADDR_IRQ_STAT, 32'h2);
    @(posedge MCLK);
    #1 chk("irq w1c", {31'h0, irq}, 32'h0);
    test_done();
  end
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
